// *** flash_host_model.sv ***
// host controller model that drives the flash link pins
module flash_host_model (
    output logic cs_n,
    output logic sck,
    output logic [3:0] line_in,
    input wire logic [1:0] dev_out,
    input wire logic [1:0] dev_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] host_d;
    // ------------------------------------------------------------
    // wire resolution: device drive wins when its enable is low
    // ------------------------------------------------------------
    assign line_in[0] = dev_oe_n[0] ? host_d[0] : dev_out[0];
    assign line_in[1] = dev_oe_n[1] ? host_d[1] : dev_out[1];
    assign line_in[3:2] = host_d[3:2];
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        host_d = 4'hf;
    end
    // ------------------------------------------------------------
    // link tasks; clock stands low outside frames
    // ------------------------------------------------------------
    task automatic sel(input logic msb);
        host_d[0] = msb;
        #30 cs_n = 1'b0;
        #62.5;
    endtask
    task automatic xfer(input logic [1:0] b, input logic drv,
                        output logic [1:0] got);
        if (drv) begin
            host_d[1:0] = b;
        end else begin
            host_d[1:0] = ~host_d[1:0];
        end
        #62.5 sck = 1'b1;
        got = line_in[1:0];
        #62.5 sck = 1'b0;
    endtask
    task automatic desel();
        #30 cs_n = 1'b1;
        host_d[1:0] = ~host_d[1:0];
        #200;
    endtask
    task automatic pin(input int idx, input logic v);
        host_d[idx] = v;
    endtask
endmodule // flash_host_model

// *** flash_sync2.sv ***
// two flip-flop synchroniser for a bundle of pin levels
module flash_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clock) begin
        if (rst) begin
            meta_q <= INIT;
            q <= INIT;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // flash_sync2

// *** serial_flash_interface_states.sv ***
// interface state sequencer of a serial flash device
// ----------------------------------------------------------------
// Overview of operation
// - low supply forces power-off; commands and pins ignored
// - after supply rise, wait power-up delay silent, then standby
// - reset low long enough starts reset; exit after processing and hold
// - optional: data_line3 acts as reset unless quad mode with select low
// - select high means standby; falling select starts instruction cycle
// - capture eight instruction bits msb first on rising clock edges
// - write-protect sampled only in write-registers instruction cycles
// - instruction picks transfer format and next interface state
// - stand-alone commands end after eighth bit; select rise gives standby
// - pause low freezes command as if clock held low
// - while paused, data_line0/1 inputs ignored and outputs floated
// - on pause release, resume in the same state
// - quad mode turns pause pin into data_line3 only
// - single input: host drives data_line0, device never drives data_line1
// - latency count taken from read_latency_code
// - latency cycles: ignore and never drive the data lines
// - single output drives data_line1, ignores input, until select rises
// - dual io read captures two address/mode bits per cycle
// - after dual address, latency if nonzero else dual output
// - after dual latency, drive two bits per cycle until select rises
// - quad_enable_bit disables pause and write-protect functions
// ----------------------------------------------------------------
module serial_flash_interface_states import serial_flash_pkg::*; #(
    parameter int PU_NS = PU_NS_DEF,
    parameter int RP_NS = RP_NS_DEF,
    parameter int RPH_NS = RPH_NS_DEF,
    parameter int RH_NS = RH_NS_DEF,
    parameter int PU_CYC = (PU_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
    parameter int RP_CYC = (RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
    parameter int RPH_CYC = (RPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
    parameter int RH_CYC = (RH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic supply_low,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic reset_n,
    input wire logic data_line0_in,
    input wire logic data_line1_in,
    input wire logic data_line2_in,
    input wire logic data_line3_in,
    output logic data_line0_out,
    output logic data_line0_oe_n,
    output logic data_line1_out,
    output logic data_line1_oe_n,
    output logic data_line2_out,
    output logic data_line2_oe_n,
    output logic data_line3_out,
    output logic data_line3_oe_n,
    input wire flash_cfg_t cfg,
    input wire logic [7:0] tx_byte,
    output logic tx_take_q,
    output rx_beat_t rx_q,
    output logic [7:0] instr_q,
    output logic instr_valid_q,
    output logic write_protect_q,
    output logic paused_q,
    output state_t state_q
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [7:0] pins_s;
    logic supply_low_s, cs_n_s, sck_s, reset_n_s;
    logic dl0_s, dl1_s, dl2_s, dl3_s;

    flash_sync2 #(.W(8), .INIT(8'hdf)) u_sync (
        .clock(clock),
        .rst(rst),
        .d({supply_low, cs_n, sck, reset_n, data_line3_in, data_line2_in,
            data_line1_in, data_line0_in}),
        .q(pins_s)
    );

    assign {supply_low_s, cs_n_s, sck_s, reset_n_s} = pins_s[7:4];
    assign {dl3_s, dl2_s, dl1_s, dl0_s} = pins_s[3:0];

    // ------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------
    state_t state_d;
    logic sck_prev_q, cs_prev_q;
    logic [5:0] bit_cnt_q, bit_cnt_d;
    logic [6:0] shift_q;
    cmd_t cmd_q;
    logic [3:0] lat_q, lat_d;
    logic [31:0] tmr_q, rp_q, rh_q;
    logic [7:0] tx_sh_q;
    logic [2:0] tx_cnt_q;
    logic drive_q;

    // ------------------------------------------------------------
    // decode of conditions
    // ------------------------------------------------------------
    wire sck_rise = sck_s & ~sck_prev_q;
    wire sck_fall = ~sck_s & sck_prev_q;
    wire cs_fall = cs_prev_q & ~cs_n_s;
    wire io3_is_reset = cfg.io3_reset_enable
                        & (~cfg.quad_enable_bit | cs_n_s);
    wire rst_pin_low = ~reset_n_s | (io3_is_reset & ~dl3_s);
    wire pause_active = ~cfg.quad_enable_bit & cfg.pause_pin_select
                        & ~cfg.io3_reset_enable & ~cs_n_s
                        & ~dl3_s;
    wire clk_rise = sck_rise & ~pause_active;
    wire clk_fall = sck_fall & ~pause_active;
    wire quiet_st = (state_q == ST_POWER_OFF) | (state_q == ST_POR)
                    | (state_q == ST_HW_RESET);
    wire rst_start = rst_pin_low & ~quiet_st
                     & (rp_q >= 32'(RP_CYC - 1));
    wire rph_done = tmr_q >= 32'(RPH_CYC - 1);
    wire rh_done = rh_q >= 32'(RH_CYC - 1);
    wire [7:0] instr_d = {shift_q, dl0_s};
    wire cmd_t cmd_d = decode_cmd(instr_d);
    wire [3:0] lat_n = LAT_CYCLES[cfg.read_latency_code];
    wire instr_done = (state_q == ST_INSTR) & clk_rise
                      & (bit_cnt_q == INSTR_LAST);
    wire out_st_d = (state_d == ST_SOUT) | (state_d == ST_DOUT);
    wire dual_st = state_q == ST_DOUT;
    wire drive_d = out_st_d & (drive_q | clk_fall);
    wire [7:0] tx_src = (tx_cnt_q == 3'h0) ? tx_byte : tx_sh_q;
    wire take = drive_d & clk_fall & (tx_cnt_q == 3'h0);
    wire state_t out_st = cmd_q.dual_out ? ST_DOUT : ST_SOUT;
    wire state_t lat_st = cmd_q.dual_addr ? ST_DLAT : ST_SLAT;
    wire state_t rd_tail = (cmd_q.lat && lat_n != 4'h0) ? lat_st : out_st;
    wire state_t instr_next = cmd_d.write_registers_cmd ? ST_SIN
                              : cmd_d.addr ? ST_SIN
                              : cmd_d.dual_addr ? ST_DIN
                              : ST_DONE;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        if (supply_low_s) begin
            state_d = ST_POWER_OFF;
        end else if (rst_start) begin
            state_d = ST_HW_RESET;
        end else begin
            unique case (state_q)
                ST_POWER_OFF: state_d = ST_POR;
                ST_POR: begin
                    if (tmr_q >= 32'(PU_CYC - 1)) begin
                        state_d = ST_STANDBY;
                    end
                end
                ST_HW_RESET: begin
                    if (rph_done && rh_done && !rst_pin_low) begin
                        state_d = ST_STANDBY;
                    end
                end
                ST_STANDBY: begin
                    if (cs_fall) begin
                        state_d = ST_INSTR;
                    end
                end
                ST_INSTR, ST_SIN, ST_SLAT, ST_SOUT, ST_DIN, ST_DLAT,
                ST_DOUT, ST_DONE: begin
                    if (cs_n_s) begin
                        state_d = ST_STANDBY;
                    end else if (clk_rise) begin
                        unique case (state_q)
                            ST_INSTR: begin
                                if (bit_cnt_q == INSTR_LAST) begin
                                    state_d = instr_next;
                                end
                            end
                            ST_SIN: begin
                                if (!cmd_q.write_registers_cmd && bit_cnt_q == ADDR_LAST) begin
                                    state_d = rd_tail;
                                end
                            end
                            ST_DIN: begin
                                if (bit_cnt_q == DUAL_ADDR_LAST) begin
                                    state_d = rd_tail;
                                end
                            end
                            ST_SLAT, ST_DLAT: begin
                                if (lat_q == 4'h1) begin
                                    state_d = out_st;
                                end
                            end
                            ST_SOUT, ST_DOUT, ST_DONE: state_d = state_q;
                            ST_POWER_OFF, ST_POR, ST_HW_RESET,
                            ST_STANDBY: state_d = state_q;
                        endcase
                    end
                end
            endcase
        end
    end

    assign bit_cnt_d = (state_d != state_q) ? 6'h00
                       : clk_rise ? bit_cnt_q + 6'h01 : bit_cnt_q;
    assign lat_d = (state_d != state_q) ? lat_n
                   : clk_rise ? lat_q - 4'h1 : lat_q;

    // ------------------------------------------------------------
    // sequencer registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= ST_POWER_OFF;
            sck_prev_q <= 1'b0;
            cs_prev_q <= 1'b1;
            bit_cnt_q <= 6'h00;
            lat_q <= 4'h0;
            paused_q <= 1'b0;
        end else begin
            state_q <= state_d;
            sck_prev_q <= sck_s;
            cs_prev_q <= cs_n_s;
            bit_cnt_q <= bit_cnt_d;
            lat_q <= lat_d;
            paused_q <= pause_active & ~quiet_st;
        end
    end

    // ------------------------------------------------------------
    // reset and power-up timers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            tmr_q <= 32'h0000_0000;
            rp_q <= 32'h0000_0000;
            rh_q <= 32'h0000_0000;
        end else begin
            tmr_q <= (state_d != state_q) ? 32'h0000_0000
                     : (tmr_q == 32'hffff_ffff) ? tmr_q : tmr_q + 32'h1;
            rp_q <= !rst_pin_low ? 32'h0000_0000
                    : (rp_q == 32'hffff_ffff) ? rp_q : rp_q + 32'h1;
            rh_q <= rst_pin_low ? 32'h0000_0000
                    : (rh_q == 32'hffff_ffff) ? rh_q : rh_q + 32'h1;
        end
    end

    // ------------------------------------------------------------
    // instruction and inbound capture
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            shift_q <= 7'h00;
            cmd_q <= '0;
            instr_q <= 8'h00;
            instr_valid_q <= 1'b0;
            write_protect_q <= 1'b0;
            rx_q <= '0;
        end else begin
            instr_valid_q <= instr_done & ~cs_n_s & ~supply_low_s
                             & ~rst_start;
            if (state_q == ST_INSTR && clk_rise) begin
                shift_q <= instr_d[6:0];
            end
            if (instr_done) begin
                instr_q <= instr_d;
                cmd_q <= cmd_d;
                if (cmd_d.write_registers_cmd && !cfg.quad_enable_bit) begin
                    write_protect_q <= ~dl2_s;
                end
            end
            rx_q.valid <= clk_rise & ~cs_n_s
                          & ((state_q == ST_SIN) | (state_q == ST_DIN));
            rx_q.dual <= state_q == ST_DIN;
            rx_q.bits <= (state_q == ST_DIN) ? {dl1_s, dl0_s}
                         : {1'b0, dl0_s};
        end
    end

    // ------------------------------------------------------------
    // outbound data, launched on falling clock edges
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            drive_q <= 1'b0;
            tx_sh_q <= 8'h00;
            tx_cnt_q <= 3'h0;
            tx_take_q <= 1'b0;
            data_line0_out <= 1'b0;
            data_line1_out <= 1'b0;
            data_line2_out <= 1'b0;
            data_line3_out <= 1'b0;
            data_line0_oe_n <= 1'b1;
            data_line1_oe_n <= 1'b1;
            data_line2_oe_n <= 1'b1;
            data_line3_oe_n <= 1'b1;
        end else begin
            drive_q <= drive_d;
            tx_take_q <= take;
            if (!out_st_d) begin
                tx_cnt_q <= 3'h0;
            end else if (drive_d && clk_fall) begin
                data_line1_out <= tx_src[7];
                data_line0_out <= dual_st ? tx_src[6] : 1'b0;
                tx_sh_q <= dual_st ? {tx_src[5:0], 2'b00}
                           : {tx_src[6:0], 1'b0};
                tx_cnt_q <= (tx_cnt_q != 3'h0) ? tx_cnt_q - 3'h1
                            : dual_st ? DUAL_BYTE_LAST : SINGLE_BYTE_LAST;
            end
            // float while paused, in latency and in every input phase
            data_line1_oe_n <= ~(drive_d & ~pause_active);
            data_line0_oe_n <= ~(drive_d & ~pause_active
                                 & (state_d == ST_DOUT));
            data_line2_oe_n <= 1'b1;
            data_line3_oe_n <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    wire active_st = ~quiet_st & (state_q != ST_STANDBY);
    wire no_abort = ~supply_low_s & ~rst_start;

    sequence s_instr_last;
        state_q == ST_INSTR && clk_rise && bit_cnt_q == INSTR_LAST
            && !cs_n_s && no_abort;
    endsequence

    sequence s_out_launch;
        drive_d && clk_fall && !supply_low_s;
    endsequence

    a_supply_low_off: assert property (supply_low_s |=>
        state_q == ST_POWER_OFF && !instr_valid_q)
        else $error("low supply did not force power-off");
    a_por_silent: assert property (state_q == ST_POR |->
        data_line0_oe_n && data_line1_oe_n && !instr_valid_q)
        else $error("device active during power-up delay");
    a_reset_exit_wait: assert property ($past(state_q) == ST_HW_RESET
        && state_q == ST_STANDBY |->
        $past(tmr_q) >= 32'(RPH_CYC - 1) && $past(rh_q) >= 32'(RH_CYC - 1))
        else $error("hardware reset left too early");
    a_cs_high_standby: assert property (cs_n_s && active_st && no_abort
        |=> state_q == ST_STANDBY)
        else $error("select high did not return to standby");
    a_instr_capture: assert property (s_instr_last |=>
        instr_valid_q && instr_q[0] == $past(dl0_s))
        else $error("instruction not captured on eighth edge");
    a_wp_only_wrr: assert property (!(instr_done && cmd_d.write_registers_cmd)
        |=> $stable(write_protect_q))
        else $error("write-protect sampled outside write-registers");
    a_pause_freeze: assert property (pause_active && active_st
        && no_abort |=> $stable(state_q) && $stable(bit_cnt_q))
        else $error("state moved while paused");
    a_pause_float: assert property (paused_q |->
        data_line0_oe_n && data_line1_oe_n)
        else $error("data lines driven while paused");
    a_quad_no_pause: assert property (cfg.quad_enable_bit |->
        !pause_active)
        else $error("pause active in quad mode");
    a_latency_float: assert property (state_q inside {ST_SLAT, ST_DLAT,
        ST_SIN, ST_DIN, ST_INSTR} |-> data_line0_oe_n && data_line1_oe_n)
        else $error("data lines driven outside output cycles");
    a_dual_zero_lat: assert property (state_q == ST_DIN && clk_rise
        && bit_cnt_q == DUAL_ADDR_LAST && lat_n == 4'h0 && !cs_n_s
        && no_abort |=> state_q == ST_DOUT)
        else $error("dual read without latency missed output");
    a_fall_launch: assert property (s_out_launch ##1 !pause_active
        |-> !data_line1_oe_n)
        else $error("output not driven after falling edge");

endmodule // serial_flash_interface_states

// *** serial_flash_interface_states_tb.sv ***
// self-checking bench for the flash interface state sequencer
module serial_flash_interface_states_tb import serial_flash_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, rst, supply_low, reset_n;
    flash_cfg_t cfg;
    logic [7:0] tx_byte, rd, instr_q;
    wire cs_n, sck;
    wire [3:0] lin;
    logic [3:0] dout, doe_n;
    logic tx_take_q, instr_valid_q, write_protect_q, paused_q;
    rx_beat_t rx_q;
    state_t state_q;
    logic [1:0] g;
    int miscompares = 0, n_compared = 0, cyc = 0;
    int n_rx = 0, n_take = 0, n_iv = 0;
    logic [1:0] rx_last;
    logic [7:0] ops [3] = '{OP_FAST_READ, OP_DUAL_OUT_READ, OP_DUAL_IO_READ};
    flash_host_model u_host (.cs_n(cs_n), .sck(sck), .line_in(lin),
        .dev_out(dout[1:0]), .dev_oe_n(doe_n[1:0]));
    serial_flash_interface_states #(.PU_CYC(20), .RPH_CYC(10))
    u_serial_flash_interface_states (.clock(clock), .rst(rst),
        .supply_low(supply_low), .cs_n(cs_n), .sck(sck), .reset_n(reset_n),
        .data_line0_in(lin[0]), .data_line1_in(lin[1]),
        .data_line2_in(lin[2]), .data_line3_in(lin[3]),
        .data_line0_out(dout[0]), .data_line0_oe_n(doe_n[0]),
        .data_line1_out(dout[1]), .data_line1_oe_n(doe_n[1]),
        .data_line2_out(dout[2]), .data_line2_oe_n(doe_n[2]),
        .data_line3_out(dout[3]), .data_line3_oe_n(doe_n[3]),
        .cfg(cfg), .tx_byte(tx_byte), .tx_take_q(tx_take_q), .rx_q(rx_q),
        .instr_q(instr_q), .instr_valid_q(instr_valid_q),
        .write_protect_q(write_protect_q), .paused_q(paused_q),
        .state_q(state_q));
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // ------------------------------------------------------------
    // compare, wait and command tasks
    // ------------------------------------------------------------
    task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic wait_st(input state_t s);
        for (int i = 0; i < 3000 && state_q !== s; i++) @(posedge clock);
        cmp(state_q, s);
    endtask
    task automatic send(input logic [7:0] op);
        int iv0;
        iv0 = n_iv;
        u_host.sel(op[7]);
        for (int i = 7; i >= 0; i--) u_host.xfer({1'b0, op[i]}, 1'b1, g);
        cmp(12'(instr_q), 12'(op));
        cmp(12'(n_iv - iv0), 12'h1);
    endtask
    task automatic rd_cmd(input logic [7:0] op, input int lat);
        logic dual_in;
        int rx0, tk0;
        dual_in = (op == OP_DUAL_IO_READ);
        send(op);
        rx0 = n_rx;
        for (int i = 0; i < (dual_in ? 16 : 24); i++) begin
            if (i == 4) begin
                u_host.pin(3, 1'b0);
                repeat (8) @(posedge clock);
                cmp(12'(paused_q), 12'h1);
                u_host.xfer(2'h0, 1'b1, g);
                cmp(state_q, dual_in ? ST_DIN : ST_SIN);
                u_host.pin(3, 1'b1);
            end
            u_host.xfer(dual_in ? 2'h2 : 2'h1, 1'b1, g);
        end
        cmp(12'(doe_n[1]), 12'h1);
        cmp(12'(n_rx - rx0), dual_in ? 12'h010 : 12'h018);
        cmp(12'(rx_last), dual_in ? 12'h2 : 12'h1);
        tk0 = n_take;
        for (int i = 0; i < lat; i++) begin
            u_host.xfer(2'h0, 1'b0, g);
            cmp(12'(doe_n[1:0]), 12'h3);
        end
        for (int i = 0; i < (op == OP_FAST_READ ? 8 : 4); i++) begin
            u_host.xfer(2'h0, 1'b0, g);
            rd = (op == OP_FAST_READ) ? {rd[6:0], g[1]} : {rd[5:0], g};
        end
        cmp(12'(n_take - tk0), 12'h1);
        cmp(12'(doe_n[3:2]), 12'h3);
        u_host.desel();
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (rx_q.valid) begin
            n_rx++;
            rx_last = rx_q.bits;
        end
        if (tx_take_q) n_take++;
        if (instr_valid_q) n_iv++;
        if (cyc == 30000) begin
            miscompares++;
            report_and_stop();
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        supply_low = 1'b0;
        reset_n = 1'b1;
        cfg = '{1'b0, 1'b1, 1'b0, 2'h0};
        tx_byte = 8'ha5;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        wait_st(ST_STANDBY);
        u_host.pin(2, 1'b0);
        for (int k = 0; k < 3; k++) begin
            @(posedge clock);
            cfg.read_latency_code <= 2'(k + 1);
            rd_cmd(ops[k], int'(LAT_CYCLES[k + 1]));
            cmp(12'(rd), 12'ha5);
            wait_st(ST_STANDBY);
        end
        cmp(12'(write_protect_q), 12'h0);
        send(OP_WRITE_REGS);
        u_host.desel();
        cmp(12'(write_protect_q), 12'h1);
        wait_st(ST_STANDBY);
        @(posedge clock);
        supply_low <= 1'b1;
        repeat (6) @(posedge clock);
        cmp(state_q, ST_POWER_OFF);
        supply_low <= 1'b0;
        wait_st(ST_STANDBY);
        reset_n <= 1'b0;
        repeat (60) @(posedge clock);
        cmp(state_q, ST_HW_RESET);
        reset_n <= 1'b1;
        wait_st(ST_STANDBY);
        report_and_stop();
    end
endmodule // serial_flash_interface_states_tb

// *** serial_flash_pkg.sv ***
// shared constants, types and command decode for the flash interface
package serial_flash_pkg;

    // ------------------------------------------------------------
    // clock and reset timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int PU_NS_DEF = 300000;
    localparam int RP_NS_DEF = 200;
    localparam int RPH_NS_DEF = 35000;
    localparam int RH_NS_DEF = 50;

    // ------------------------------------------------------------
    // frame geometry
    // ------------------------------------------------------------
    localparam logic [5:0] INSTR_LAST = 6'h07;
    localparam logic [5:0] ADDR_LAST = 6'h17;
    localparam logic [5:0] DUAL_ADDR_LAST = 6'h0f;
    localparam logic [2:0] SINGLE_BYTE_LAST = 3'h7;
    localparam logic [2:0] DUAL_BYTE_LAST = 3'h3;
    // latency cycles per read_latency_code value
    localparam logic [3:0][3:0] LAT_CYCLES = {4'h0, 4'h2, 4'h4, 4'h8};

    // ------------------------------------------------------------
    // opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_WRITE_REGS = 8'h11;
    localparam logic [7:0] OP_READ = 8'h21;
    localparam logic [7:0] OP_FAST_READ = 8'h31;
    localparam logic [7:0] OP_DUAL_OUT_READ = 8'h41;
    localparam logic [7:0] OP_DUAL_IO_READ = 8'h51;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [11:0] {
        ST_POWER_OFF = 12'h001,
        ST_POR = 12'h002,
        ST_HW_RESET = 12'h004,
        ST_STANDBY = 12'h008,
        ST_INSTR = 12'h010,
        ST_SIN = 12'h020,
        ST_SLAT = 12'h040,
        ST_SOUT = 12'h080,
        ST_DIN = 12'h100,
        ST_DLAT = 12'h200,
        ST_DOUT = 12'h400,
        ST_DONE = 12'h800
    } state_t;

    typedef struct packed {
        logic quad_enable_bit;
        logic pause_pin_select;
        logic io3_reset_enable;
        logic [1:0] read_latency_code;
    } flash_cfg_t;

    typedef struct packed {
        logic valid;
        logic dual;
        logic [1:0] bits;
    } rx_beat_t;

    typedef struct packed {
        logic addr;
        logic dual_addr;
        logic lat;
        logic dual_out;
        logic write_registers_cmd;
    } cmd_t;

    function automatic cmd_t decode_cmd(input logic [7:0] op);
        cmd_t c;
        c = '0;
        case (op)
            OP_WRITE_REGS: c.write_registers_cmd = 1'b1;
            OP_READ: c.addr = 1'b1;
            OP_FAST_READ: c = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
            OP_DUAL_OUT_READ: c = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
            OP_DUAL_IO_READ: c = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
            default: c = '0;
        endcase
        return c;
    endfunction

endpackage
